/* File: dv/scd_clock_sync_sva.sv */
/* Port checker for the clock block.
   Assumes a bind to every instance. */
`timescale 1ns/1ps
module scd_chk (
  input wire       clk,
  input wire       reset_n,
  input wire       reg_wr,
  input wire [8:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire [7:0] reg_rdata_q,
  input wire       sense_at_supply,
  input wire       samp_en_q,
  input wire       restored_clk_q,
  input wire       restorer_valid_q,
  input wire       ext_ref_sel_q,
  input wire [2:0] span_code_q
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  // Register path and derived outputs
  AST_SPAN: assert property (reg_wr && reg_addr == 9'h018 && reg_wdata[7:6] == 2'h3
    && reg_wdata[2:0] == 3'h0 && reg_wdata[5:3] < 3'h5
    |-> ##2 span_code_q == $past(reg_wdata[5:3], 2)) else $error("span");
  AST_RDATA: assert property ((reg_wr && reg_addr == 9'h018) ##1
    (!reg_wr && reg_addr == 9'h018) |=> reg_rdata_q == $past(reg_wdata, 2)) else $error("rd");
  AST_UNMAP: assert property (reg_addr == 9'h055 |=> reg_rdata_q == 8'h00) else $error("map");
  AST_REF_HI: assert property ($rose(sense_at_supply) |-> ##5 ext_ref_sel_q) else $error("ref");
  AST_REF_LO: assert property ($fell(sense_at_supply) |-> ##5 !ext_ref_sel_q) else $error("ref");
  // Restored clock rises only together with a sample pulse
  AST_RISE: assert property ($rose(restored_clk_q) |-> samp_en_q) else $error("rise");
  AST_SAMP_HI: assert property (samp_en_q |-> restored_clk_q) else $error("edge");
  AST_SAMP: assert property (samp_en_q |-> ##[1:16] samp_en_q) else $error("samp");
  AST_VLD_LO: assert property (reg_wr && reg_addr == 9'h00b |-> ##2 !restorer_valid_q) else $error("v");
  AST_VLD_HI: assert property ((reg_wr && reg_addr == 9'h00b && reg_wdata[3]) ##1 !reg_wr [*8]
    |-> restorer_valid_q) else $error("relock");
endmodule
bind scd_clock_sync scd_chk u_chk (
  .clk              (clk),
  .reset_n          (reset_n),
  .reg_wr           (reg_wr),
  .reg_addr         (reg_addr),
  .reg_wdata        (reg_wdata),
  .reg_rdata_q      (reg_rdata_q),
  .sense_at_supply  (sense_at_supply),
  .samp_en_q        (samp_en_q),
  .restored_clk_q   (restored_clk_q),
  .restorer_valid_q (restorer_valid_q),
  .ext_ref_sel_q    (ext_ref_sel_q),
  .span_code_q      (span_code_q)
);

/* File: dv/scd_sync_src.sv */
/* Sync pulse source at the sync pin.
   Assumes fire is a one-clock request. */
`timescale 1ns/1ps
module scd_sync_src (
  input  wire  clk,
  input  wire  fire,
  output logic sync_in
);
  logic [2:0] cnt_q = 3'h0;
  // Pulse held six clocks, then low
  always @(posedge clk) begin
    if (fire) cnt_q <= 3'h6;
    else if (cnt_q != 3'h0) cnt_q <= cnt_q - 3'h1;
  end
  assign sync_in = (cnt_q != 3'h0);
endmodule

/* File: dv/testbench.sv */
/* Bench for the clock block.
   Assumes the sync source model and checker. */
`timescale 1ns/1ps
module testbench;
  logic        clk = 1'b0, reset_n = 1'b0, reg_wr = 1'b0, fire = 1'b0, rd_p = 1'b0;
  logic        sense_at_supply = 1'b0;
  logic [8:0]  reg_addr = 9'h000;
  logic [7:0]  reg_wdata = 8'h00, exp_q[$];
  logic [31:0] rng = 32'h4334;
  wire  [7:0]  reg_rdata_q;
  wire  [2:0]  span_code_q;
  wire         sync_in, samp_en_q, restored_clk_q, restorer_valid_q, ext_ref_sel_q;
  int          failures = 0, n_compared = 0, p, d, e, k, h;
  logic [7:0]  cd [5] = '{8'hc0, 8'hc8, 8'hd0, 8'hd8, 8'he0};
  // Clock and parts
  always #25 clk = ~clk;
  scd_clock_sync #(.RELOCK_CYC(4)) dut (
    .clk              (clk),
    .reset_n          (reset_n),
    .reg_wr           (reg_wr),
    .reg_addr         (reg_addr),
    .reg_wdata        (reg_wdata),
    .reg_rdata_q      (reg_rdata_q),
    .sync_in          (sync_in),
    .sense_at_supply  (sense_at_supply),
    .samp_en_q        (samp_en_q),
    .restored_clk_q   (restored_clk_q),
    .restorer_valid_q (restorer_valid_q),
    .ext_ref_sel_q    (ext_ref_sel_q),
    .span_code_q      (span_code_q)
  );
  scd_sync_src u_src (.clk(clk), .fire(fire), .sync_in(sync_in));
  // Xorshift step for random stimulus
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction
  task automatic chk(input logic [7:0] got, input logic [7:0] want);
    n_compared++;
    if (got !== want) begin
      failures++;
      $display("MISMATCH %0t got %h want %h", $time, got, want);
    end
  endtask
  // Oldest note against each read result
  always @(posedge clk) if (rd_p) chk(reg_rdata_q, exp_q.pop_front());
  task automatic wr(input logic [8:0] a, input logic [7:0] v);
    @(negedge clk) {reg_wr, reg_addr, reg_wdata} = {1'b1, a, v};
    @(negedge clk) reg_wr = 1'b0;
  endtask
  task automatic rd(input logic [8:0] a, input logic [7:0] v);
    @(negedge clk) reg_addr = a;
    exp_q.push_back(v);
    @(negedge clk) rd_p = 1'b1;
    @(negedge clk) rd_p = 1'b0;
  endtask
  // Cycles between two sample pulses, and restored-clock high cycles
  task automatic per(output int n, output int hi);
    n = 0;
    hi = 0;
    while (samp_en_q !== 1'b1 && n < 20) @(negedge clk) n++;
    n = 0;
    do begin
      @(negedge clk);
      n++;
      if (restored_clk_q === 1'b1) hi++;
    end while (samp_en_q !== 1'b1 && n < 20);
  endtask
  // Cycles from a sync pulse to a later sample pulse
  task automatic meas(output int n);
    @(negedge clk) fire = 1'b1;
    @(negedge clk) fire = 1'b0;
    n = 1;
    while ((n < 9 || samp_en_q !== 1'b1) && n < 40) @(negedge clk) n++;
  endtask
  task automatic stop_test;
    $display("compared %0d mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    repeat (20) @(negedge clk);
    reset_n = 1'b1;
    rd(9'h018, 8'he0);
    chk({5'h0, span_code_q}, 8'h04);
    for (int i = 0; i < 5; i++) begin
      wr(9'h018, cd[i]);
      rd(9'h018, cd[i]);
      chk({5'h0, span_code_q}, 8'(i));
    end
    rng = xs(rng);
    wr(9'h055, rng[7:0]);
    rd(9'h055, 8'h00);
    for (int s = 1; s >= 0; s--) begin
      sense_at_supply = 1'(s);
      repeat (5) @(negedge clk);
      chk({7'h0, ext_ref_sel_q}, 8'(s));
    end
    $display("span and reference done");
    for (int n = 1; n <= 8; n++) begin
      k = (n != 1 && n != 2 && n != 4);
      wr(9'h00b, 8'(k * 8 + n - 1));
      repeat (8) @(negedge clk);
      per(p, h);
      chk(8'(p), 8'(n));
      chk(8'(h), 8'(k ? n / 2 : 1));
      rd(9'h00b, 8'(k * 136 + n - 1));
    end
    $display("divider done");
    wr(9'h100, 8'h02);
    meas(d);
    meas(e);
    chk(8'(e), 8'(d));
    wr(9'h100, 8'h04);
    meas(e);
    chk(8'(e), 8'(d));
    repeat ((10 - d % 8) % 8) @(negedge clk);
    meas(e);
    chk({7'h0, e != d}, 8'h01);
    $display("sync done");
    stop_test;
  end
  // About 300 clocks of tests; over ten times that
  initial begin
    #(50 * 4000);
    failures++;
    stop_test;
  end
endmodule

/* File: rtl/scd_clock_sync.v */
/*
  Sample-clock divider with sync realignment, duty-cycle restorer
  and register-selected input span; reference mode from sense pin.
  Assumes clk is the sample clock and a simple register write/read port.
  The sync and sense pins arrive from outside the clock domain and are
  filtered by three flops here; register signals are already on clk.
  The restored clock is a registered image of the conditioned clock,
  so its edges land on input clock edges only.
*/
`timescale 1ns/1ps
`include "scd_defs.vh"

// Notes on behaviour
// - The sample clock is divided by any whole ratio from one to eight.
// - Sync control bits 1 and 2 choose realign on every pulse or first only.
// - An accepted sync pulse returns the divider to its initial state.
// - The restorer keeps the rising edge and makes a half-period high time.
// - The restorer output is flagged unusable below twenty megahertz.
// - The span register selects 1.0, 1.14, 1.33, 1.6 or 2.0 V spans.
// - Sense at ground selects internal reference, at supply an external one.
// - Sampling is on the conditioned clock rising edge, kept by both paths.
module scd_clock_sync #(
  parameter RELOCK_CYC = (`SCD_RELOCK_MAX_NS / `SCD_CLK_PERIOD_NS)
) (
  input  wire       clk,
  input  wire       reset_n,
  input  wire       reg_wr,
  input  wire [8:0] reg_addr,
  input  wire [7:0] reg_wdata,
  output reg  [7:0] reg_rdata_q,
  input  wire       sync_in,
  input  wire       sense_at_supply,
  output reg        samp_en_q,
  output reg        restored_clk_q,
  output reg        restorer_valid_q,
  output reg        ext_ref_sel_q,
  output reg  [2:0] span_code_q
);

  // Register storage
  reg [7:0] span_q;
  reg [7:0] sync_ctl_q;
  reg [7:0] div_q;
  reg       sync_armed_q;
  // Input synchronisers
  reg [2:0] sync_pipe_q;
  reg [2:0] sense_pipe_q;
  reg       sync_lvl_q;
  reg       sense_lvl_q;
  // Divider
  reg [2:0] cnt_q;
  reg [2:0] half_q;
  reg [15:0] lock_q;

  wire [2:0] ratio_m1  = div_q[`SCD_DIV_LSB+2:`SCD_DIV_LSB];
  wire       dcr_en    = div_q[`SCD_DCR_EN_BIT];
  wire       sync_rise = sync_pipe_q[1] & sync_pipe_q[2] & ~sync_lvl_q;
  wire       sync_every = sync_ctl_q[`SCD_SYNC_EN_BIT];
  wire       sync_first = sync_ctl_q[`SCD_SYNC_FIRST_BIT];
  // Accepted pulse under selected mode
  wire       sync_take = sync_rise & (sync_every | (sync_first & sync_armed_q));
  wire       wr_sync   = reg_wr & (reg_addr == `SCD_OFS_SYNC);

  // Map span code to a three-bit index
  function [2:0] span_idx;
    input [7:0] code;
    begin
      case (code)
        `SCD_SPAN_1V00: span_idx = 3'h0;
        `SCD_SPAN_1V14: span_idx = 3'h1;
        `SCD_SPAN_1V33: span_idx = 3'h2;
        `SCD_SPAN_1V60: span_idx = 3'h3;
        default:        span_idx = 3'h4;
      endcase
    end
  endfunction

  // Whole division ratio from the stored ratio-minus-one field
  function [3:0] div_len;
    input [2:0] m1;
    begin
      div_len = {1'b0, m1} + 4'h1;
    end
  endfunction

  // High time of the restored clock, half the ratio rounded down
  function [3:0] high_len;
    input [2:0] m1;
    begin
      high_len = div_len(m1) >> 1;
    end
  endfunction

  // Register address decode shared by the span and divider write strobes
  function addr_hit;
    input [8:0] addr;
    input [8:0] ofs;
    begin
      addr_hit = (addr == ofs);
    end
  endfunction

  // Write strobes per register
  wire       wr_span = reg_wr & addr_hit(reg_addr, `SCD_OFS_SPAN);
  wire       wr_div  = reg_wr & addr_hit(reg_addr, `SCD_OFS_DIV);
  // Restored high span for the programmed ratio; four bits hold ratio eight
  wire [3:0] high_n  = high_len(ratio_m1);

  // Register writes
  always @(posedge clk) begin
    if (!reset_n) begin
      span_q     <= `SCD_SPAN_RST;
      sync_ctl_q <= `SCD_SYNC_RST;
      div_q      <= `SCD_DIV_RST;
    end else if (reg_wr) begin
      if (wr_span)
        span_q <= reg_wdata;
      if (wr_sync)
        sync_ctl_q <= reg_wdata;
      if (wr_div)
        div_q <= reg_wdata;
    end
  end

  // First-pulse arming; a write re-arms, acceptance disarms
  always @(posedge clk) begin
    if (!reset_n)
      sync_armed_q <= 1'b0;
    else if (wr_sync)
      sync_armed_q <= 1'b1;
    else if (sync_take)
      sync_armed_q <= 1'b0;
  end

  // Read mux
  always @(posedge clk) begin
    if (!reset_n)
      reg_rdata_q <= 8'h00;
    else begin
      case (reg_addr)
        `SCD_OFS_SPAN: reg_rdata_q <= span_q;
        `SCD_OFS_SYNC: reg_rdata_q <= sync_ctl_q;
        `SCD_OFS_DIV:  reg_rdata_q <= {restorer_valid_q, ext_ref_sel_q, 2'h0, div_q[3:0]};
        default:       reg_rdata_q <= 8'h00;
      endcase
    end
  end

  // Pin synchronisers, change counts when stages two and three agree
  // Stage one feeds only stage two, so a metastable first stage never leaks
  always @(posedge clk) begin
    if (!reset_n) begin
      sync_pipe_q  <= 3'h0;
      sense_pipe_q <= 3'h0;
      sync_lvl_q   <= 1'b0;
      sense_lvl_q  <= 1'b0;
    end else begin
      sync_pipe_q  <= {sync_pipe_q[1:0], sync_in};
      sense_pipe_q <= {sense_pipe_q[1:0], sense_at_supply};
      if (sync_pipe_q[1] == sync_pipe_q[2])
        sync_lvl_q <= sync_pipe_q[2];
      if (sense_pipe_q[1] == sense_pipe_q[2])
        sense_lvl_q <= sense_pipe_q[2];
    end
  end

  // Divider: one sample enable every ratio_m1+1 edges
  always @(posedge clk) begin
    if (!reset_n) begin
      cnt_q     <= 3'h0;
      samp_en_q <= 1'b0;
    end else if (sync_take) begin
      cnt_q     <= 3'h0;
      samp_en_q <= 1'b0;
    end else begin
      samp_en_q <= (cnt_q == 3'h0);
      cnt_q     <= (cnt_q == ratio_m1) ? 3'h0 : cnt_q + 3'h1;
    end
  end

  // Restored clock: high from the sample edge for half the period with the restorer on, one cycle with it off
  always @(posedge clk) begin
    if (!reset_n) begin
      half_q         <= 3'h0;
      restored_clk_q <= 1'b0;
    end else if (!dcr_en) begin
      half_q         <= 3'h0;
      restored_clk_q <= (cnt_q == 3'h0) & ~sync_take;
    end else if ((cnt_q == 3'h0) && !sync_take) begin
      half_q         <= 3'h0;
      restored_clk_q <= 1'b1;
    end else begin
      // Compare in four bits so a ratio of eight keeps four high cycles
      half_q         <= half_q + 3'h1;
      restored_clk_q <= restored_clk_q & (({1'b0, half_q} + 4'h1) < high_n);
    end
  end

  // Relock wait and low-rate qualification of the restorer
  always @(posedge clk) begin
    // A divider write restarts the wait, as the sample rate may have moved
    if (!reset_n || !dcr_en || wr_div)
      lock_q <= 16'h0000;
    else if (lock_q != RELOCK_CYC[15:0])
      lock_q <= lock_q + 16'h0001;
  end

  always @(posedge clk) begin
    if (!reset_n) begin
      restorer_valid_q <= 1'b0;
      ext_ref_sel_q    <= 1'b0;
      span_code_q      <= 3'h4;
    end else begin
      restorer_valid_q <= dcr_en && (lock_q == RELOCK_CYC[15:0]) &&
                          (`SCD_CLK_MHZ >= `SCD_DCR_MIN_MHZ);
      ext_ref_sel_q    <= sense_lvl_q;
      span_code_q      <= span_idx(span_q);
    end
  end

endmodule

/* File: rtl/scd_defs.vh */
/*
  Constants for the sample-clock conditioning block: register offsets,
  field positions, reset values, span codes and timing counts.
  Assumes inclusion by bare name from the design file only.
*/
`ifndef SCD_DEFS_VH
`define SCD_DEFS_VH

// Register offsets
`define SCD_OFS_SPAN        9'h018
`define SCD_OFS_SYNC        9'h100
`define SCD_OFS_DIV         9'h00b
// Sync control fields
`define SCD_SYNC_EN_BIT     1
`define SCD_SYNC_FIRST_BIT  2
// Divider register fields
`define SCD_DIV_LSB         0
`define SCD_DCR_EN_BIT      3
// Reset values
`define SCD_SPAN_RST        8'he0
`define SCD_SYNC_RST        8'h00
`define SCD_DIV_RST         8'h00
// Span codes
`define SCD_SPAN_1V00       8'hc0
`define SCD_SPAN_1V14       8'hc8
`define SCD_SPAN_1V33       8'hd0
`define SCD_SPAN_1V60       8'hd8
`define SCD_SPAN_2V00       8'he0
// Timing
`define SCD_CLK_MHZ         20
`define SCD_DCR_MIN_MHZ     20
`define SCD_RELOCK_MAX_NS   5000
`define SCD_CLK_PERIOD_NS   50

`endif
